// ### pkg/ses_map.vh
/*
 * constants of the serial eeprom slave: opcodes, status layout,
 * protection bases, reset values and the write cycle timing.
 * assumes inclusion by its bare name from the design files.
 */
`ifndef SES_MAP_VH
`define SES_MAP_VH

// opcodes
`define SES_OP_READ    8'h03
`define SES_OP_WRITE   8'h02
`define SES_OP_LCLR    8'h04
`define SES_OP_LSET    8'h06
`define SES_OP_SRD     8'h05
`define SES_OP_SWR     8'h01

// status byte fields
`define SES_SR_PPE     7
`define SES_SR_BPH     3
`define SES_SR_BPL     2
`define SES_SR_WEL     1
`define SES_SR_BUSY    0
`define SES_SR_DC      3'h0

// block protect codes and lowest protected address
`define SES_BP_NONE    2'h0
`define SES_BP_QTR     2'h1
`define SES_BP_HALF    2'h2
`define SES_BP_ALL     2'h3
`define SES_BASE_QTR   10'h300
`define SES_BASE_HALF  10'h200

// reset and idle values
`define SES_RST_BP     2'h0
`define SES_RST_PPE    1'b0
`define SES_RST_BYTE   8'h00
`define SES_IDLE_BYTE  8'hff

// bit counts
`define SES_BYTE_LAST  3'h7
`define SES_ADDR_LAST  4'hf

// geometry
`define SES_AW         10
`define SES_PW         4

// write cycle: 5 ms at 250 MHz
`define SES_TWC_MS     5
`define SES_CLK_MHZ    250
`define SES_KHZ_PER_MHZ 1000
`define SES_TMR_W      21

`endif

// ### hw/ses_buf.v
/*
 * two-entry buffer with valid/ready on both sides and a flush.
 * assumes a single clock; flush wins over any push in its cycle.
 */
`timescale 1ns/10ps
module ses_buf #(
  parameter W = 8
)(
  // clock, reset and flush
  input  wire         i_clk,
  input  wire         i_rst,
  input  wire         i_flush,
  // fill side
  input  wire         i_valid,
  input  wire [W-1:0] i_data,
  output wire         o_ready,
  // drain side
  output wire         o_valid,
  output wire [W-1:0] o_data,
  input  wire         i_ready
);

  reg [W-1:0] e0;
  reg [W-1:0] e1;
  reg [1:0]   cnt;

  wire push = i_valid & o_ready;
  wire pop  = o_valid & i_ready;

  assign o_ready = (cnt != 2'h2);
  assign o_valid = (cnt != 2'h0);
  assign o_data  = e0;

  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt <= 2'h0;
      e0  <= {W{1'b0}};
      e1  <= {W{1'b0}};
    end else if (i_flush) begin
      cnt <= 2'h0;
    end else if (push & pop) begin
      // only reachable with one entry held
      e0 <= i_data;
    end else if (push) begin
      if (cnt == 2'h0) begin
        e0 <= i_data;
      end else begin
        e1 <= i_data;
      end
      cnt <= cnt + 2'h1;
    end else if (pop) begin
      e0  <= e1;
      cnt <= cnt - 2'h1;
    end
  end

endmodule

// ### hw/ses_slave.v
/*
 * command interpreter of a 1024-byte spi serial eeprom: opcode decode,
 * array read with prefetch buffer, page write, latch and status ops,
 * self-timed write and block/pin protection.
 * assumes all pins are asynchronous to I_CLK and sck is far slower.
 */
`timescale 1ns/10ps
`include "ses_map.vh"
// Contract
// - each command shifts into an 8-bit opcode from rising sck after select.
// - opcode, address and data travel msb first in both directions.
// - after a hold pause, resume at the exact bit it began.
// - read is 03h, 16-bit address, top six ignored, then data out.
// - read address increments per byte and wraps top to zero.
// - read ends as soon as select rises.
// - latch sets only at select rise after complete enable opcode.
// - write is 02h, 16-bit address, one to sixteen bytes in one page.
// - write advances low four address bits only, wrapping within page.
// - internal write starts only if select rises right after a D0.
// - during internal write ignore array access, still answer status reads.
// - latch clears at reset, disable opcode and completed writes.
// - 06h sets the latch and 04h clears it.
// - 05h returns the status byte at any time, even while busy.
// - status: pin enable 7, dont-care 6-4, protect 3-2, latch 1, busy 0.
// - busy reads one during internal write; writes to it ignored.
// - latch bit read-only; enable/disable always act regardless of protection.
// - 01h writes protect pair: none, 300h up, 200h up, whole array.
// - protect pin low with pin enable set refuses status writes.
// - no write completes without latch; protected blocks never written.
// - after reset idle, latch clear, output off; select fall activates.
// - output changes after falling sck, off whenever deselected.
// - internal write lasts at most 5 ms, then busy clears.
module ses_slave #(
  parameter TWC_CYC = `SES_TWC_MS * `SES_CLK_MHZ * `SES_KHZ_PER_MHZ,
  parameter AW      = `SES_AW,
  parameter PW      = `SES_PW
)(
  // clock and reset
  input  wire I_CLK,
  input  wire I_RST,
  // spi link
  input  wire I_CS_N,
  input  wire I_SCK,
  input  wire I_SI,
  output reg  O_SO,
  output wire O_SO_OE_N,
  // pause and protection pins
  input  wire I_HOLD_N,
  input  wire I_WP_N
);

  localparam [8:0] ST_IDLE  = 9'h001;
  localparam [8:0] ST_OP    = 9'h002;
  localparam [8:0] ST_ADDR  = 9'h004;
  localparam [8:0] ST_RDATA = 9'h008;
  localparam [8:0] ST_WDATA = 9'h010;
  localparam [8:0] ST_SRD   = 9'h020;
  localparam [8:0] ST_SWR   = 9'h040;
  localparam [8:0] ST_END   = 9'h080;
  localparam [8:0] ST_IGN   = 9'h100;

  localparam DEPTH = 1 << AW;
  localparam NPG   = 1 << PW;
  localparam [31:0] TWC_M1 = TWC_CYC - 1;

  // synchronisers; stage 0 feeds only stage 1
  reg [2:0] cs_q;
  reg [2:0] sck_q;
  reg [1:0] si_q;
  reg [1:0] hold_q;
  reg [1:0] wp_q;

  reg [8:0]          state;
  reg [3:0]          cnt;
  reg [15:0]         sh;
  reg [7:0]          op;
  reg [AW-1:0]       addr;
  reg [AW-1:0]       pf_addr;
  reg [NPG-1:0]      mask;
  reg                byte_done;
  reg [2:0]          tx_cnt;
  reg [7:0]          tx_sh;
  reg                drive;
  reg                hold_act;
  reg                armed;
  reg                write_enable_latch;
  reg                busy;
  reg [`SES_TMR_W-1:0] tmr;
  reg                sr_pend;
  reg [7:0]          sr_new;
  reg                ppe;
  reg [1:0]          bp;

  reg [7:0] mem [0:DEPTH-1];
  reg [7:0] pg  [0:NPG-1];

  // pause freezes sck edges so only a select rise moves sequence state
  wire cs_rise  = cs_q[1] & ~cs_q[2];
  wire cs_fall  = ~cs_q[1] & cs_q[2] & armed;
  wire sck_rise = sck_q[1] & ~sck_q[2] & ~hold_act & ~cs_q[1];
  wire sck_fall = ~sck_q[1] & sck_q[2] & ~hold_act & ~cs_q[1];

  wire [7:0]    rx_byte = {sh[6:0], si_q[1]};
  wire [AW-1:0] rx_addr = {sh[AW-2:0], si_q[1]};
  wire          byte_end = (cnt[2:0] == `SES_BYTE_LAST);

  wire st_rdata = (state == ST_RDATA);
  wire [7:0] status = {ppe, `SES_SR_DC, bp, write_enable_latch, busy};
  wire hw_prot = ppe & ~wp_q[1];
  wire [AW-1:0] pbase = {addr[AW-1:PW], {PW{1'b0}}};
  wire pg_prot = (bp == `SES_BP_ALL) |
                 ((bp == `SES_BP_QTR) & (pbase >= `SES_BASE_QTR)) |
                 ((bp == `SES_BP_HALF) & (pbase >= `SES_BASE_HALF));
  wire tmr_end = busy & (tmr == TWC_M1[`SES_TMR_W-1:0]);
  wire commit  = tmr_end & ~sr_pend;

  wire       bq_ready;
  wire       bq_valid;
  wire [7:0] bq_data;
  wire [7:0] pf_data = mem[pf_addr];
  wire       tx_load = sck_fall & (tx_cnt == 3'h0);
  wire       pop     = tx_load & st_rdata;
  wire       pg_we   = sck_rise & ~cs_fall & (state == ST_WDATA) & byte_end;

  // prefetch keeps the serializer fed; stall holds the prefetch address
  ses_buf #(
    .W (8)
  ) u_buf (
    .i_clk   (I_CLK),
    .i_rst   (I_RST),
    .i_flush (~st_rdata),
    .i_valid (st_rdata),
    .i_data  (pf_data),
    .o_ready (bq_ready),
    .o_valid (bq_valid),
    .o_data  (bq_data),
    .i_ready (pop)
  );

  wire [7:0] tx_byte = (state == ST_SRD) ? status :
                       (bq_valid ? bq_data : `SES_IDLE_BYTE);

  // output off while deselected, paused or not sending
  assign O_SO_OE_N = ~drive | hold_act | cs_q[1];

  always @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      cs_q      <= 3'h7;
      sck_q     <= 3'h0;
      si_q      <= 2'h0;
      hold_q    <= 2'h3;
      wp_q      <= 2'h3;
      state     <= ST_IDLE;
      cnt       <= 4'h0;
      sh        <= 16'h0000;
      op        <= `SES_RST_BYTE;
      addr      <= {AW{1'b0}};
      pf_addr   <= {AW{1'b0}};
      mask      <= {NPG{1'b0}};
      byte_done <= 1'b0;
      tx_cnt    <= 3'h0;
      tx_sh     <= `SES_RST_BYTE;
      O_SO      <= 1'b1;
      drive     <= 1'b0;
      hold_act  <= 1'b0;
      armed     <= 1'b0;
      write_enable_latch       <= 1'b0;
      busy      <= 1'b0;
      tmr       <= {`SES_TMR_W{1'b0}};
      sr_pend   <= 1'b0;
      sr_new    <= `SES_RST_BYTE;
      ppe       <= `SES_RST_PPE;
      bp        <= `SES_RST_BP;
    end else begin
      cs_q   <= {cs_q[1:0], I_CS_N};
      sck_q  <= {sck_q[1:0], I_SCK};
      si_q   <= {si_q[0], I_SI};
      hold_q <= {hold_q[0], I_HOLD_N};
      wp_q   <= {wp_q[0], I_WP_N};

      // a select fall counts once cs_q[1] was high after reset; its reset value arms it at the first clock
      if (cs_q[1]) begin
        armed <= 1'b1;
      end
      // pause taken only while sck is low; released while sck is low or at once on deselect
      if (cs_q[1]) begin
        hold_act <= 1'b0;
      end else if (!sck_q[1]) begin
        hold_act <= ~hold_q[1];
      end

      if (st_rdata & bq_ready) begin
        pf_addr <= pf_addr + {{(AW-1){1'b0}}, 1'b1};
      end

      // self-timed write; deselect does not stop it
      if (busy) begin
        if (tmr_end) begin
          busy <= 1'b0;
          tmr  <= {`SES_TMR_W{1'b0}};
          write_enable_latch  <= 1'b0;
          if (sr_pend) begin
            ppe <= sr_new[`SES_SR_PPE];
            bp  <= sr_new[`SES_SR_BPH:`SES_SR_BPL];
          end
        end else begin
          tmr <= tmr + {{(`SES_TMR_W-1){1'b0}}, 1'b1};
        end
      end

      if (cs_rise) begin
        state <= ST_IDLE;
        drive <= 1'b0;
        if (state == ST_END) begin
          if (op == `SES_OP_LSET) begin
            write_enable_latch <= 1'b1;
          end else if (op == `SES_OP_LCLR) begin
            write_enable_latch <= 1'b0;
          end else if (op == `SES_OP_SWR && write_enable_latch && !hw_prot) begin
            busy    <= 1'b1;
            sr_pend <= 1'b1;
          end
        end
        if (state == ST_WDATA && byte_done && write_enable_latch && !pg_prot) begin
          busy    <= 1'b1;
          sr_pend <= 1'b0;
        end
      end else if (cs_fall) begin
        state  <= ST_OP;
        cnt    <= 4'h0;
        tx_cnt <= 3'h0;
      end else if (sck_rise) begin
        sh  <= {sh[14:0], si_q[1]};
        cnt <= cnt + 4'h1;
        case (state)
          ST_OP: begin
            if (byte_end) begin
              cnt <= 4'h0;
              op  <= rx_byte;
              case (rx_byte)
                `SES_OP_READ: begin
                  state <= busy ? ST_IGN : ST_ADDR;
                end
                `SES_OP_WRITE: begin
                  state <= (busy | ~write_enable_latch) ? ST_IGN : ST_ADDR;
                end
                `SES_OP_LSET, `SES_OP_LCLR: begin
                  state <= ST_END;
                end
                `SES_OP_SRD: begin
                  state <= ST_SRD;
                end
                `SES_OP_SWR: begin
                  state <= busy ? ST_IGN : ST_SWR;
                end
                default: begin
                  state <= ST_IGN;
                end
              endcase
            end
          end
          ST_ADDR: begin
            if (cnt == `SES_ADDR_LAST) begin
              cnt       <= 4'h0;
              addr      <= rx_addr;
              pf_addr   <= rx_addr;
              mask      <= {NPG{1'b0}};
              byte_done <= 1'b0;
              state     <= (op == `SES_OP_READ) ? ST_RDATA : ST_WDATA;
            end
          end
          ST_WDATA: begin
            byte_done <= byte_end;
            if (byte_end) begin
              cnt                 <= 4'h0;
              mask[addr[PW-1:0]]  <= 1'b1;
              addr[PW-1:0]        <= addr[PW-1:0] + {{(PW-1){1'b0}}, 1'b1};
            end
          end
          ST_SWR: begin
            if (byte_end) begin
              sr_new <= rx_byte;
              state  <= ST_END;
            end
          end
          ST_END: begin
            // a stray clock after the byte abandons the command
            state <= ST_IGN;
          end
          ST_RDATA, ST_SRD: begin
            if (byte_end) begin
              cnt <= 4'h0;
            end
          end
          default: begin
            cnt <= 4'h0;
          end
        endcase
      end else if (sck_fall) begin
        if (st_rdata || state == ST_SRD) begin
          drive  <= 1'b1;
          tx_cnt <= tx_cnt + 3'h1;
          if (tx_load) begin
            O_SO  <= tx_byte[7];
            tx_sh <= {tx_byte[6:0], 1'b0};
          end else begin
            O_SO  <= tx_sh[7];
            tx_sh <= {tx_sh[6:0], 1'b0};
          end
        end
      end
    end
  end

  // array and page storage carry no reset
  integer i;
  always @(posedge I_CLK) begin
    if (pg_we) begin
      pg[addr[PW-1:0]] <= rx_byte;
    end
    if (commit) begin
      for (i = 0; i < NPG; i = i + 1) begin
        if (mask[i]) begin
          mem[{addr[AW-1:PW], i[PW-1:0]}] <= pg[i];
        end
      end
    end
  end

endmodule

// ### tb/ses_slave_properties.sv
/* pin-level assertions for the serial eeprom slave.
   assumes sck half periods of at least 8 clocks. */
`timescale 1ns/10ps
module ses_slave_properties (
  // clock and reset
  input wire I_CLK,
  input wire I_RST,
  // link and pins
  input wire I_CS_N,
  input wire I_SCK,
  input wire I_SI,
  input wire O_SO,
  input wire O_SO_OE_N,
  input wire I_HOLD_N,
  input wire I_WP_N
);
  reg       sck_q;
  reg [3:0] sf;
  reg [4:0] nr;
  reg [7:0] op;

  // clocks since sck fell, rises in frame, first byte of frame
  always @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      sck_q <= 1'b0;
      sf    <= 4'hf;
      nr    <= 5'h0;
      op    <= 8'h0;
    end else begin
      sck_q <= I_SCK;
      sf    <= (sck_q && !I_SCK) ? 4'h0 : sf + {3'h0, sf != 4'hf};
      if (I_CS_N)
        nr <= 5'h0;
      else if (!sck_q && I_SCK && I_HOLD_N && nr != 5'h1f) begin
        nr <= nr + 5'h1;
        if (nr < 5'h8)
          op <= {op[6:0], I_SI};
      end
    end
  end

  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_RST);

  chk_off_deselect: assert property (I_CS_N [*6] |-> O_SO_OE_N)
    else $error("so driven while deselected");
  chk_so_timing: assert property (!O_SO_OE_N && $past(!O_SO_OE_N) && $changed(O_SO) |-> sf inside {[1:7]})
    else $error("so moved away from an sck fall");
  chk_oe_on_fall: assert property ($fell(O_SO_OE_N) && $past(I_HOLD_N, 6) |-> sf inside {[1:7]})
    else $error("so enabled away from an sck fall");
  chk_oe_bit_count: assert property ($fell(O_SO_OE_N) && $past(I_HOLD_N, 6) |-> nr == 5'h8 || nr == 5'h18)
    else $error("so enabled after wrong bit count");
  chk_pause_off: assert property ((!I_HOLD_N && !I_SCK) [*6] |-> O_SO_OE_N)
    else $error("so driven while paused");
  chk_reset_idle: assert property ($fell(I_RST) |-> O_SO_OE_N && O_SO)
    else $error("so not idle after reset");
  chk_unknown_quiet: assert property (!O_SO_OE_N |-> op == 8'h03 || op == 8'h05)
    else $error("so driven for a silent opcode");
  chk_off_after_cs: assert property ($rose(I_CS_N) |-> ##[1:5] O_SO_OE_N)
    else $error("so still driven after deselect");

  cover property ($fell(O_SO_OE_N) && nr == 5'h18);
  cover property ($fell(O_SO_OE_N) && nr == 5'h8);
  cover property (!I_HOLD_N && !I_CS_N);
endmodule

bind ses_slave ses_slave_properties chk (
  .I_CLK(I_CLK), .I_RST(I_RST), .I_CS_N(I_CS_N), .I_SCK(I_SCK), .I_SI(I_SI),
  .O_SO(O_SO), .O_SO_OE_N(O_SO_OE_N), .I_HOLD_N(I_HOLD_N), .I_WP_N(I_WP_N));

// ### tb/ses_host.sv
/* spi host model: frames whole commands on the slave's pins.
   assumes 16 clocks per sck period. */
`timescale 1ns/10ps
module ses_host (
  // clock
  input  wire i_clk,
  // link
  input  wire i_so,
  input  wire i_so_oe_n,
  output reg  o_cs_n,
  output reg  o_sck,
  output reg  o_si,
  output reg  o_hold_n
);
  initial begin
    o_cs_n   = 1'b1;
    o_sck    = 1'b0;
    o_si     = 1'b0;
    o_hold_n = 1'b1;
  end

  task automatic wt(input int n);
    repeat (n) @(posedge i_clk);
  endtask

  // so read just before each rise; undriven reads as x
  task automatic xfer(input int n, input logic [63:0] d, input int p, output logic [63:0] q);
    q = 'x;
    o_cs_n <= 1'b0;
    wt(8);
    for (int i = n - 1; i >= 0; i--) begin
      o_sck <= 1'b0;
      o_si  <= d[i];
      wt(8);
      q = {q[62:0], i_so_oe_n ? 1'bx : i_so};
      if (i == p) begin
        o_hold_n <= 1'b0;
        wt(8);
        repeat (2) begin
          o_sck <= 1'b1;
          wt(8);
          o_sck <= 1'b0;
          wt(8);
        end
        o_hold_n <= 1'b1;
        wt(8);
      end
      o_sck <= 1'b1;
      wt(8);
    end
    o_sck <= 1'b0;
    wt(8);
    o_cs_n <= 1'b1;
    o_si   <= ~o_si;
    wt(16);
  endtask
endmodule

// ### tb/ses_slave_tb.sv
/* self-checking bench: host frames commands, status polls check.
   assumes the checker binds itself from its own file. */
`timescale 1ns/10ps
module ses_slave_tb;
  logic        clk  = 1'b0;
  logic        rst  = 1'b1;
  logic        wp_n = 1'b1;
  wire         cs_n, sck, si, hold_n, so, so_oe_n;
  logic [63:0] q;
  logic [7:0]  v;
  int          num_errors = 0;
  int          num_checks = 0;

  always #2 clk = ~clk;

  ses_slave #(.TWC_CYC(1500)) dut (
    .I_CLK(clk), .I_RST(rst), .I_CS_N(cs_n), .I_SCK(sck), .I_SI(si),
    .O_SO(so), .O_SO_OE_N(so_oe_n), .I_HOLD_N(hold_n), .I_WP_N(wp_n));
  ses_host host (
    .i_clk(clk), .i_so(so), .i_so_oe_n(so_oe_n), .o_cs_n(cs_n),
    .o_sck(sck), .o_si(si), .o_hold_n(hold_n));

  task automatic chk(input string nm, input logic [7:0] s, e);
    num_checks++;
    if (s !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic cmd(input int n, input logic [63:0] d);
    host.xfer(n, d, -1, q);
  endtask

  // status poll, optionally paused before bit p
  task automatic st(input int p = -1);
    host.xfer(16, 64'h0500, p, q);
    v = q[7:0];
  endtask

  // bounded wait for the write cycle to end
  task automatic idle;
    st();
    repeat (8) if (v[0] !== 1'b0) st();
    chk("busy_end", {7'h0, v[0]}, 8'h00);
  endtask

  task summarize;
    if (num_errors == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge clk);
    num_errors++;
    summarize();
  end

  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    repeat (8) @(posedge clk);
    st();
    chk("sr_reset", v, 8'h00);
    cmd(32, 64'h020010aa);
    st();
    chk("sr_no_latch", v, 8'h00);
    cmd(40, 64'h06020010aa);
    st();
    chk("sr_same_sel", v, 8'h00);
    cmd(8, 64'h06);
    st();
    chk("sr_set", v, 8'h02);
    cmd(8, 64'h04);
    st();
    chk("sr_clear", v, 8'h00);
    cmd(8, 64'h06);
    cmd(48, 64'h02040e112233);
    st();
    chk("sr_busy", v, 8'h03);
    cmd(32, 64'h03000e00);
    chk("rd_busy", q[7:0], 8'hxx);
    // a write sent while busy must not touch the page being programmed
    cmd(40, 64'h02000e7700);
    idle();
    chk("sr_done", v, 8'h00);
    cmd(8, 64'h06);
    cmd(32, 64'h0203ff5a);
    idle();
    cmd(40, 64'h0307ff0000);
    chk("rd_top", q[15:8], 8'h5a);
    chk("rd_wrap", q[7:0], 8'h33);
    cmd(40, 64'h03000e0000);
    chk("rd_page0", q[15:8], 8'h11);
    chk("rd_page1", q[7:0], 8'h22);
    cmd(8, 64'h06);
    cmd(35, 64'h10000d2d);
    st();
    chk("sr_abandon", v, 8'h02);
    cmd(16, 64'h018f);
    idle();
    chk("sr_write", v, 8'h8c);
    cmd(8, 64'h06);
    cmd(32, 64'h020000c3);
    st();
    chk("sr_prot_all", v, 8'h8e);
    wp_n <= 1'b0;
    cmd(16, 64'h0100);
    idle();
    chk("sr_pin_prot", v, 8'h8e);
    wp_n <= 1'b1;
    for (int b = 1; b < 3; b++) begin
      cmd(8, 64'h06);
      cmd(16, 64'h0100 + 64'(b * 4));
      idle();
      chk("sr_bp", v, 8'(b * 4));
      cmd(8, 64'h06);
      cmd(32, b == 1 ? 64'h020300a0 : 64'h020200a0);
      st();
      chk("sr_prot", v, 8'(b * 4 + 2));
      cmd(32, b == 1 ? 64'h0202ffa0 : 64'h0201ffa0);
      st();
      chk("sr_open", v, 8'(b * 4 + 3));
      idle();
    end
    cmd(16, 64'hff00);
    chk("unknown_op", q[7:0], 8'hxx);
    st(11);
    chk("sr_paused", v, 8'h08);
    // pause while the status byte is on its way out
    st(5);
    chk("sr_paused_out", v, 8'h08);
    summarize();
  end
endmodule
